// ---- ddrdec_buf2.sv ----
// Two-entry record buffer with valid/ready on both sides.
// Assumes both sides run on clk_in; reset is synchronous active low.
`timescale 1ns/1ps
`default_nettype none

module ddrdec_buf2
   import ddrdec_pkg::*;
#(
   parameter int unsigned WIDTH = $bits(ddrdec_rec_t),
   parameter int unsigned DEPTH = 2
)
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // Filling side
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   // Draining side
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);

   localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [PTR_W:0] CNT_FULL = (PTR_W+1)'(DEPTH);
   localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] mem_d [DEPTH];
   logic [PTR_W-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
   logic [PTR_W:0] cnt_q, cnt_d;
   logic push, pop;

   // Honest full and empty drive both handshakes
   assign in_ready_out = (cnt_q != CNT_FULL);
   assign out_valid_out = (cnt_q != '0);
   assign out_data_out = mem_q[rd_ptr_q];
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;

   ////////////////////////////////////////////////////////////////////////
   // Pointer and storage update
   always_comb
   begin
      wr_ptr_d = wr_ptr_q;
      rd_ptr_d = rd_ptr_q;
      cnt_d = cnt_q;
      mem_d = mem_q;
      if (push)
      begin
         mem_d[wr_ptr_q] = in_data_in;
         wr_ptr_d = (wr_ptr_q == PTR_LAST) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop)
      begin
         rd_ptr_d = (rd_ptr_q == PTR_LAST) ? '0 : rd_ptr_q + 1'b1;
      end
      if (push && !pop)
      begin
         cnt_d = cnt_q + 1'b1;
      end
      else if (pop && !push)
      begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
      begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         cnt_q <= '0;
         mem_q <= '{default: '0};
      end
      else
      begin
         wr_ptr_q <= wr_ptr_d;
         rd_ptr_q <= rd_ptr_d;
         cnt_q <= cnt_d;
         mem_q <= mem_d;
      end
   end

endmodule

`default_nettype wire

// ---- ddrdec_ctrl_model.sv ----
// Controller-side model of the monitored bus: one bus cycle per call.
// Assumes the caller steps it once per clock, just after a falling edge.
`timescale 1ns/1ps
`default_nettype none

module ddrdec_ctrl_model
   import ddrdec_pkg::*;
(
   // Driven bus pins
   output var ddrdec_bus_t bus_out
);
   // Idle bus: nothing selected
   initial bus_out = '1;

   // Data lines change every cycle so a stale beat never looks valid
   task automatic drive(input logic [3:0] cs, input logic [2:0] op,
      input logic [15:0] a, input logic [2:0] b, input logic [31:0] rnd);
      bus_out.cs_n = cs;
      {bus_out.ras_n, bus_out.cas_n, bus_out.we_n} = op;
      bus_out.addr = a;
      bus_out.bank = b;
      bus_out.upper_data_half = rnd;
      bus_out.lower_data_half = ~rnd;
      bus_out.write_byte_masks = rnd[7:0];
   endtask
endmodule

`default_nettype wire

// ---- ddrdec_pkg.sv ----
// Package for the bus cycle decoder: widths, encodings, carriers.
// Assumes one bus clock and a synchronous active-low reset.
`default_nettype none

package ddrdec_pkg;

   // Bus widths
   localparam int unsigned RANK_W = 2;
   localparam int unsigned BANK_W = 3;
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned HALF_W = 32;
   localparam int unsigned MASK_W = 8;
   localparam int unsigned ELAP_W = 16;
   localparam int unsigned LAT_W = 4;
   localparam int unsigned DLY_W = 6;
   localparam int unsigned SCHED_D = 32;

   // Address bit positions used by decode
   localparam int unsigned A10_BIT = 10;
   localparam int unsigned A12_BIT = 12;

   // Latency limits and defaults in bus cycles
   localparam logic [LAT_W-1:0] CL_MIN = 4'h5;
   localparam logic [LAT_W-1:0] CL_MAX = 4'hA;
   localparam logic [LAT_W-1:0] WL_MIN = 4'h5;
   localparam logic [LAT_W-1:0] WL_MAX = 4'h8;
   localparam logic [DLY_W-1:0] AL_M1 = 6'h01;
   localparam logic [DLY_W-1:0] AL_M2 = 6'h02;
   localparam logic [DLY_W-1:0] REG_EXTRA = 6'h01;

   // Beats per burst
   localparam logic [DLY_W-1:0] BEATS_4 = 6'h04;
   localparam logic [DLY_W-1:0] BEATS_8 = 6'h08;

   // Elapsed counter values
   localparam logic [ELAP_W-1:0] ELAP_ONE = 16'h0001;
   localparam logic [ELAP_W-1:0] ELAP_MAX = 16'hFFFF;

   // Active-low chip select patterns
   localparam logic [3:0] CS_RANK0 = 4'hE;
   localparam logic [3:0] CS_RANK1 = 4'hD;
   localparam logic [3:0] CS_RANK2 = 4'hB;
   localparam logic [3:0] CS_RANK3 = 4'h7;

   // Row strobe, column strobe, write enable opcodes
   localparam logic [2:0] OP_MODE = 3'h0;
   localparam logic [2:0] OP_REFRESH = 3'h1;
   localparam logic [2:0] OP_PRECHG = 3'h2;
   localparam logic [2:0] OP_ACTIVATE = 3'h3;
   localparam logic [2:0] OP_WRITE = 3'h4;
   localparam logic [2:0] OP_READ = 3'h5;
   localparam logic [2:0] OP_ZQ = 3'h6;
   localparam logic [2:0] OP_NOP = 3'h7;

   typedef enum logic [1:0] {BL_FIXED4, BL_FIXED8, BL_ON_FLY} ddrdec_bl_t;
   typedef enum logic [1:0] {AL_ZERO, AL_CL_M1, AL_CL_M2} ddrdec_al_t;
   typedef enum logic [1:0]
      {VIEW_ALL, VIEW_NO_IDLE, VIEW_CMD_DATA, VIEW_DATA} ddrdec_view_t;
   typedef enum logic [1:0] {TAG_NONE, TAG_READ, TAG_WRITE} ddrdec_tag_t;
   typedef enum logic [3:0]
   {
      CMD_DESELECT, CMD_MODE_SET, CMD_REFRESH, CMD_PRECHG_BANK,
      CMD_PRECHG_ALL, CMD_ACTIVATE, CMD_WRITE, CMD_WRITE_AP,
      CMD_READ, CMD_READ_AP, CMD_NOP, CMD_ZQ_LONG, CMD_ZQ_SHORT
   } ddrdec_cmd_t;

   // One bus cycle as seen on the pins
   typedef struct packed {
      logic [3:0] cs_n;
      logic [BANK_W-1:0] bank;
      logic [ADDR_W-1:0] addr;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic [HALF_W-1:0] upper_data_half;
      logic [HALF_W-1:0] lower_data_half;
      logic [MASK_W-1:0] write_byte_masks;
   } ddrdec_bus_t;

   // Decoder settings
   typedef struct packed {
      ddrdec_bl_t burst;
      logic [LAT_W-1:0] read_lat;
      ddrdec_al_t add_lat;
      logic [LAT_W-1:0] write_lat;
      logic registered;
      logic dm_strobe;
      ddrdec_view_t view;
   } ddrdec_cfg_t;

   localparam ddrdec_cfg_t CFG_RESET = '{BL_FIXED4, CL_MIN, AL_ZERO,
                                         WL_MIN, 1'b0, 1'b0, VIEW_ALL};

   // One emitted record
   typedef struct packed {
      ddrdec_cmd_t cmd;
      logic [RANK_W-1:0] rank;
      logic [BANK_W-1:0] bank;
      logic [1:0] mode_reg;
      logic [ADDR_W-1:0] addr;
      ddrdec_tag_t tag;
      logic [HALF_W-1:0] upper_data_half;
      logic [HALF_W-1:0] lower_data_half;
      logic [MASK_W-1:0] write_byte_masks;
      logic masks_are_strobes;
      logic [ELAP_W-1:0] elapsed;
   } ddrdec_rec_t;

endpackage

`default_nettype wire

// ---- ddrdec_top.sv ----
// Passive decoder of a DDR3 command, address and data bus.
// Assumes the bus pins are sampled on clk_in, the bus clock itself,
// and that one data beat is presented per clock cycle.
//
// Notes on behaviour
// RL1 - Burst of 4, 8 or on-the-fly 4/8; tag exactly that many beats.
// RL2 - Read latency 5 to 10 cycles, default 5, to first read beat.
// RL3 - Additive latency 0, CL-1 or CL-2 is added to read delay.
// RL4 - Write latency 5 to 8 cycles, default 5, to first write beat.
// RL5 - Registered module adds one cycle to read and write beat tagging.
// RL6 - Mask lines act as write masks by default, else as strobes.
// RL7 - Unfiltered view emits a record for every bus cycle.
// RL8 - Idle-suppressing view drops idle and wait cycle records only.
// RL9 - Command-and-data view keeps address commands and data beats.
// RL10 - Data-only view keeps only tagged read or write beats.
// RL11 - Elapsed time counts from the previously emitted record.
// RL12 - Records leave oldest first, data beats at their own bus time.
// RL13 - No chip select asserted gives a deselect record.
// RL14 - Mode set reports mode register number 0 to 3 and chip select.
// RL15 - Activate reports chip select, bank and address.
// RL16 - Read reports chip select, bank, auto precharge; starts timing.
// RL17 - Write reports chip select, bank, auto precharge; starts timing.
// RL18 - Single bank precharge differs from precharge of all banks.
// RL19 - Refresh, no-op, long and short calibration carry chip select.
// RL20 - Beats inside read or write windows are labelled as data.
// RL21 - Opcode from row, column, write strobes; A10 selects variant.
// RL22 - One-hot low chip select picks rank; none asserted is deselect.
// RL23 - Reset drops pending windows and restores default settings.
// RL24 - Overlapping bursts from back-to-back commands tracked apart.
`timescale 1ns/1ps
`default_nettype none

module ddrdec_top
   import ddrdec_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // Monitored bus
   input wire ddrdec_bus_t bus_in,
   // Settings
   input wire ddrdec_cfg_t cfg_in,
   // Record stream
   output ddrdec_rec_t rec_out,
   output logic rec_valid_out,
   input wire logic rec_ready_in,
   // Overrun status
   input wire logic overrun_clr_in,
   output logic overrun_out
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   ddrdec_bus_t cap_q, cap_d;
   ddrdec_cfg_t cfg_q, cfg_d;
   logic [SCHED_D-1:0] rd_sched_q, rd_sched_d;
   logic [SCHED_D-1:0] wr_sched_q, wr_sched_d;
   logic [ELAP_W-1:0] elap_q, elap_d;
   logic overrun_q, overrun_d;
   ddrdec_cmd_t cur_cmd;
   logic [RANK_W-1:0] cur_rank;
   logic [2:0] opcode;
   logic a10;
   logic is_read, is_write;
   logic [DLY_W-1:0] cl_x, wl_x, al_x, rd_delay, wr_delay, beats;
   ddrdec_tag_t cur_tag;
   ddrdec_rec_t rec;
   logic is_idle, is_addr_cmd, is_data, keep;
   logic buf_ready, push;

   ////////////////////////////////////////////////////////////////////////
   // Capture stage and settings; reset restores defaults
   always_comb
   begin
      cap_d = bus_in;
      cfg_d = cfg_in;
      // Out-of-range latencies fall back to defaults, not to garbage
      if (cfg_in.read_lat < CL_MIN || cfg_in.read_lat > CL_MAX)
      begin
         cfg_d.read_lat = CL_MIN;
      end
      if (cfg_in.write_lat < WL_MIN || cfg_in.write_lat > WL_MAX)
      begin
         cfg_d.write_lat = WL_MIN;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
      begin
         cap_q <= '0;
         cfg_q <= CFG_RESET; // RL23
      end
      else
      begin
         cap_q <= cap_d;
         cfg_q <= cfg_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Command and rank decode of the captured cycle
   assign opcode = {cap_q.ras_n, cap_q.cas_n, cap_q.we_n};
   assign a10 = cap_q.addr[A10_BIT];

   always_comb
   begin
      cur_rank = '0;
      cur_cmd = CMD_DESELECT;
      // Multiple selects low is not a legal command; shown as deselect
      unique case (cap_q.cs_n) // RL22
         CS_RANK0: cur_rank = 2'h0;
         CS_RANK1: cur_rank = 2'h1;
         CS_RANK2: cur_rank = 2'h2;
         CS_RANK3: cur_rank = 2'h3;
         default: cur_rank = '0;
      endcase
      if (cap_q.cs_n == CS_RANK0 || cap_q.cs_n == CS_RANK1 ||
          cap_q.cs_n == CS_RANK2 || cap_q.cs_n == CS_RANK3)
      begin
         unique case (opcode) // RL21
            OP_MODE: cur_cmd = CMD_MODE_SET; // RL14
            OP_REFRESH: cur_cmd = CMD_REFRESH; // RL19
            OP_PRECHG: cur_cmd = a10 ? CMD_PRECHG_ALL : CMD_PRECHG_BANK; // RL18
            OP_ACTIVATE: cur_cmd = CMD_ACTIVATE; // RL15
            OP_WRITE: cur_cmd = a10 ? CMD_WRITE_AP : CMD_WRITE; // RL17
            OP_READ: cur_cmd = a10 ? CMD_READ_AP : CMD_READ; // RL16
            OP_ZQ: cur_cmd = a10 ? CMD_ZQ_LONG : CMD_ZQ_SHORT; // RL19
            OP_NOP: cur_cmd = CMD_NOP; // RL19
         endcase
      end
   end

   assign is_read = (cur_cmd == CMD_READ) || (cur_cmd == CMD_READ_AP);
   assign is_write = (cur_cmd == CMD_WRITE) || (cur_cmd == CMD_WRITE_AP);

   ////////////////////////////////////////////////////////////////////////
   // Data delays and burst size from the settings
   always_comb
   begin
      cl_x = DLY_W'(cfg_q.read_lat);
      wl_x = DLY_W'(cfg_q.write_lat);
      unique case (cfg_q.add_lat) // RL3
         AL_CL_M1: al_x = cl_x - AL_M1;
         AL_CL_M2: al_x = cl_x - AL_M2;
         default: al_x = '0;
      endcase
      rd_delay = cl_x + al_x + (cfg_q.registered ? REG_EXTRA : '0); // RL2 RL5
      wr_delay = wl_x + (cfg_q.registered ? REG_EXTRA : '0); // RL4 RL5
      unique case (cfg_q.burst) // RL1
         BL_FIXED8: beats = BEATS_8;
         BL_ON_FLY: beats = cap_q.addr[A12_BIT] ? BEATS_8 : BEATS_4;
         default: beats = BEATS_4;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Beat schedule: entry i stands for i+1 cycles ahead. Each command ORs
   // its own window in, so overlapping bursts never disturb each other.
   generate
      for (genvar i = 0; i < SCHED_D; i++)
      begin : g_sched
         localparam logic [DLY_W-1:0] AHEAD = DLY_W'(i + 1);
         logic rd_next, wr_next;
         if (i == SCHED_D - 1)
         begin : g_last
            assign rd_next = 1'b0;
            assign wr_next = 1'b0;
         end
         else
         begin : g_mid
            assign rd_next = rd_sched_q[i+1];
            assign wr_next = wr_sched_q[i+1];
         end
         always_comb
         begin
            rd_sched_d[i] = rd_next || (is_read && AHEAD >= rd_delay &&
                            AHEAD < rd_delay + beats); // RL16 RL24
            wr_sched_d[i] = wr_next || (is_write && AHEAD >= wr_delay &&
                            AHEAD < wr_delay + beats); // RL17 RL24
         end
      end
   endgenerate

   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
      begin
         rd_sched_q <= '0; // RL23
         wr_sched_q <= '0; // RL23
      end
      else
      begin
         rd_sched_q <= rd_sched_d;
         wr_sched_q <= wr_sched_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Record for the current cycle; a beat is tagged at its own bus time
   always_comb
   begin
      // A read/write clash on one beat is a bus fault; read is shown
      cur_tag = rd_sched_q[0] ? TAG_READ :
                (wr_sched_q[0] ? TAG_WRITE : TAG_NONE); // RL20 RL12
      rec = '0;
      rec.cmd = cur_cmd; // RL13
      rec.tag = cur_tag;
      if (cur_cmd != CMD_DESELECT)
      begin
         rec.rank = cur_rank;
         rec.bank = cap_q.bank;
         rec.addr = cap_q.addr;
      end
      if (cur_cmd == CMD_MODE_SET)
      begin
         rec.mode_reg = cap_q.bank[1:0]; // RL14
      end
      if (cur_tag != TAG_NONE)
      begin
         rec.upper_data_half = cap_q.upper_data_half;
         rec.lower_data_half = cap_q.lower_data_half;
      end
      rec.masks_are_strobes = cfg_q.dm_strobe;
      if (cfg_q.dm_strobe)
      begin
         rec.write_byte_masks = cap_q.write_byte_masks; // RL6
      end
      else if (cur_tag == TAG_WRITE)
      begin
         rec.write_byte_masks = cap_q.write_byte_masks; // RL6
      end
      rec.elapsed = elap_q; // RL11
   end

   ////////////////////////////////////////////////////////////////////////
   // View level filter
   assign is_data = (cur_tag != TAG_NONE);
   assign is_idle = !is_data &&
                    (cur_cmd == CMD_DESELECT || cur_cmd == CMD_NOP);
   assign is_addr_cmd = (cur_cmd == CMD_ACTIVATE) || is_read || is_write;

   always_comb
   begin
      unique case (cfg_q.view)
         VIEW_ALL: keep = 1'b1; // RL7
         VIEW_NO_IDLE: keep = !is_idle; // RL8
         VIEW_CMD_DATA: keep = is_addr_cmd || is_data; // RL9
         VIEW_DATA: keep = is_data; // RL10
      endcase
   end

   // The bus cannot be stalled, so a full buffer drops and flags
   assign push = keep && buf_ready;

   ////////////////////////////////////////////////////////////////////////
   // Elapsed counter and sticky overrun; a new overrun beats the clear
   always_comb
   begin
      if (push)
      begin
         elap_d = ELAP_ONE; // RL11
      end
      else if (elap_q == ELAP_MAX)
      begin
         elap_d = elap_q;
      end
      else
      begin
         elap_d = elap_q + ELAP_ONE;
      end
      overrun_d = overrun_q;
      if (overrun_clr_in)
      begin
         overrun_d = 1'b0;
      end
      if (keep && !buf_ready)
      begin
         overrun_d = 1'b1;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
      begin
         elap_q <= '0;
         overrun_q <= 1'b0;
      end
      else
      begin
         elap_q <= elap_d;
         overrun_q <= overrun_d;
      end
   end

   assign overrun_out = overrun_q;

   ////////////////////////////////////////////////////////////////////////
   // Output buffer keeps records in order across receiver stalls
   ddrdec_buf2 #(
      .WIDTH($bits(ddrdec_rec_t)),
      .DEPTH(2)
   ) u_buf (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .in_valid_in(keep),
      .in_ready_out(buf_ready),
      .in_data_in(rec),
      .out_valid_out(rec_valid_out),
      .out_ready_in(rec_ready_in),
      .out_data_out(rec_out)
   );

   ////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_rd_cmd5;
      is_read && rd_delay == 6'h05 && beats == BEATS_4;
   endsequence
   sequence s_four_read_beats;
      (cur_tag == TAG_READ) [*4];
   endsequence

   a_rank_one_decode: assert property (@(posedge clk_in) // RL22
      disable iff (!rst_b_in)
      (cap_q.cs_n == CS_RANK1 && cur_cmd != CMD_DESELECT) |-> cur_rank == 2'h1)
      else $error("rank decode wrong");
   a_deselect_record: assert property (@(posedge clk_in) // RL13
      disable iff (!rst_b_in)
      (cap_q.cs_n == 4'hF) |-> (rec.cmd == CMD_DESELECT && rec.addr == '0))
      else $error("deselect record carries a command");
   a_read_burst_four: assert property (@(posedge clk_in) // RL1
      disable iff (!rst_b_in)
      (s_rd_cmd5 and (rd_sched_q == '0)) ##1 (!is_read) [*8] |=>
      (cur_tag != TAG_READ))
      else $error("read burst length wrong");
   a_read_first_beat: assert property (@(posedge clk_in) // RL2
      disable iff (!rst_b_in)
      (s_rd_cmd5 and (rd_sched_q == '0)) |-> ##5 s_four_read_beats)
      else $error("read beats not at latency");
   a_write_first_beat: assert property (@(posedge clk_in) // RL4
      disable iff (!rst_b_in)
      (is_write && wr_delay == 6'h05 && rd_sched_q == '0 &&
       wr_sched_q == '0) |->
      ##4 (cur_tag != TAG_WRITE) ##1 (cur_tag == TAG_WRITE))
      else $error("write beat not at latency");
   a_registered_delay: assert property (@(posedge clk_in) // RL5
      disable iff (!rst_b_in)
      (cfg_q.registered && $stable(cfg_q)) |-> wr_delay == wl_x + 6'h01)
      else $error("registered delay missing");
   a_data_only_view: assert property (@(posedge clk_in) // RL10
      disable iff (!rst_b_in)
      (push && cfg_q.view == VIEW_DATA) |-> rec.tag != TAG_NONE)
      else $error("non-data record in data view");
   a_idle_dropped: assert property (@(posedge clk_in) // RL8
      disable iff (!rst_b_in)
      (cfg_q.view == VIEW_NO_IDLE && is_idle) |-> !keep)
      else $error("idle record kept");
   a_elapsed_restart: assert property (@(posedge clk_in) // RL11
      disable iff (!rst_b_in)
      push |=> (elap_q == ELAP_ONE) ##1 ($past(push) || elap_q == 16'h0002))
      else $error("elapsed not restarted");
   a_reset_clears: assert property (@(posedge clk_in) // RL23
      !rst_b_in |=> (rd_sched_q == '0 && wr_sched_q == '0 &&
                     cfg_q == CFG_RESET))
      else $error("reset left pending windows");
   a_mode_reg_num: assert property (@(posedge clk_in) // RL14
      disable iff (!rst_b_in)
      (cur_cmd == CMD_MODE_SET) |-> rec.mode_reg == cap_q.bank[1:0])
      else $error("mode register number wrong");

endmodule

`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the bus cycle decoder.
// Assumes a record leaves two cycles after its bus cycle, via 2 entries.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   import ddrdec_pkg::*;
   logic clk_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic rec_ready_in = 1'b1;
   logic overrun_clr_in = 1'b0;
   ddrdec_bus_t bus;
   ddrdec_cfg_t cfg = CFG_RESET;
   ddrdec_rec_t rec;
   logic rec_valid;
   logic overrun;
   ddrdec_rec_t exp_q[$];
   bit el_q[$];
   ddrdec_tag_t tagm[int];
   int fail_count, check_count, now, last, skip_e, room, cyc_n;
   bit quiet, first;
   logic [31:0] lf = 32'h0000_0037;
   int rl[6] = '{5, 10, 7, 6, 9, 8};

   ddrdec_ctrl_model ctrl_model_i (.bus_out(bus));
   ddrdec_top ddrdec_top_i (.clk_in(clk_in), .rst_b_in(rst_b_in),
      .bus_in(bus), .cfg_in(cfg), .rec_out(rec), .rec_valid_out(rec_valid),
      .rec_ready_in(rec_ready_in), .overrun_clr_in(overrun_clr_in),
      .overrun_out(overrun));

   // 100 ns bus clock
   always #50 clk_in = ~clk_in;

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] nxt(logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction

   function automatic ddrdec_cmd_t dec(logic [3:0] cs, logic [2:0] op,
      logic ap);
      if (!(cs inside {CS_RANK0, CS_RANK1, CS_RANK2, CS_RANK3}))
         return CMD_DESELECT;
      case (op)
         3'h0: return CMD_MODE_SET;
         3'h1: return CMD_REFRESH;
         3'h2: return ap ? CMD_PRECHG_ALL : CMD_PRECHG_BANK;
         3'h3: return CMD_ACTIVATE;
         3'h4: return ap ? CMD_WRITE_AP : CMD_WRITE;
         3'h5: return ap ? CMD_READ_AP : CMD_READ;
         3'h6: return ap ? CMD_ZQ_LONG : CMD_ZQ_SHORT;
         default: return CMD_NOP;
      endcase
   endfunction

   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         fail_count++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask

   task automatic chk_rec(ddrdec_rec_t e, bit el);
      chk("cmd", 32'(e.cmd), 32'(rec.cmd));
      chk("rank", 32'(e.rank), 32'(rec.rank));
      chk("tag", 32'(e.tag), 32'(rec.tag));
      chk("upper", e.upper_data_half, rec.upper_data_half);
      chk("lower", e.lower_data_half, rec.lower_data_half);
      chk("masks", 32'(e.write_byte_masks), 32'(rec.write_byte_masks));
      chk("dm", 32'(e.masks_are_strobes), 32'(rec.masks_are_strobes));
      if (e.cmd inside {CMD_ACTIVATE, CMD_READ, CMD_WRITE, CMD_PRECHG_BANK})
         chk("bank", 32'(e.bank), 32'(rec.bank));
      if (e.cmd == CMD_ACTIVATE)
         chk("addr", 32'(e.addr), 32'(rec.addr));
      if (e.cmd == CMD_MODE_SET)
         chk("mreg", 32'(e.mode_reg), 32'(rec.mode_reg));
      if (el)
         chk("elapsed", 32'(e.elapsed), 32'(rec.elapsed));
   endtask

   // Drive one bus cycle and note the record the decoder should emit
   task automatic step(logic [3:0] cs, logic [2:0] op, logic [15:0] a,
      logic [2:0] b);
      ddrdec_rec_t e;
      ddrdec_cmd_t c;
      ddrdec_tag_t t;
      int n, d;
      bit k;
      lf = nxt(lf);
      ctrl_model_i.drive(cs, op, a, b, lf);
      now++;
      c = dec(cs, op, a[A10_BIT]);
      n = (cfg.burst == BL_FIXED8 || (cfg.burst == BL_ON_FLY && a[12]))
         ? 8 : 4;
      d = cfg.read_lat + cfg.registered + (cfg.add_lat == AL_CL_M1 ?
         cfg.read_lat - 1 : cfg.add_lat == AL_CL_M2 ? cfg.read_lat - 2 : 0);
      // Reads win where windows coincide; later bursts overlap earlier
      for (int i = 0; i < n; i++)
      begin
         if (c inside {CMD_READ, CMD_READ_AP})
            tagm[now + d + i] = TAG_READ;
         if (c inside {CMD_WRITE, CMD_WRITE_AP} &&
            !(tagm.exists(now + cfg.write_lat + cfg.registered + i) &&
            tagm[now + cfg.write_lat + cfg.registered + i] == TAG_READ))
            tagm[now + cfg.write_lat + cfg.registered + i] = TAG_WRITE;
      end
      t = tagm.exists(now) ? tagm[now] : TAG_NONE;
      e = '0;
      e.cmd = c;
      e.rank = c == CMD_DESELECT ? 2'h0 : cs == CS_RANK1 ? 2'h1 :
         cs == CS_RANK2 ? 2'h2 : cs == CS_RANK3 ? 2'h3 : 2'h0;
      e.bank = b;
      e.addr = a;
      e.mode_reg = b[1:0];
      e.tag = t;
      e.masks_are_strobes = cfg.dm_strobe;
      if (t != TAG_NONE)
         {e.upper_data_half, e.lower_data_half} = {lf, ~lf};
      if (cfg.dm_strobe || t == TAG_WRITE)
         e.write_byte_masks = lf[7:0];
      e.elapsed = 16'(now - last);
      case (cfg.view)
         VIEW_ALL: k = 1'b1;
         VIEW_NO_IDLE: k = !(c inside {CMD_DESELECT, CMD_NOP}) ||
            t != TAG_NONE;
         VIEW_CMD_DATA: k = t != TAG_NONE || c inside {CMD_ACTIVATE,
            CMD_READ, CMD_READ_AP, CMD_WRITE, CMD_WRITE_AP};
         default: k = t != TAG_NONE;
      endcase
      // A full buffer during a stall drops the record unseen
      if (k && !quiet && room > 0)
      begin
         if (!rec_ready_in)
            room--;
         exp_q.push_back(e);
         el_q.push_back(!first);
         first = 1'b0;
         last = now;
      end
      @(negedge clk_in);
   endtask

   task automatic idle(int n);
      repeat (n) step(4'hF, 3'h7, 16'h0000, 3'h0);
   endtask

   // Reset with new settings; records in flight meanwhile are ignored
   task automatic start(int r, ddrdec_cfg_t c);
      rst_b_in = 1'b0;
      cfg = c;
      skip_e = r + 5;
      exp_q.delete();
      el_q.delete();
      tagm.delete();
      repeat (r) @(negedge clk_in);
      rst_b_in = 1'b1;
      quiet = 1'b1;
      idle(3);
      quiet = 1'b0;
      first = 1'b1;
      room = 2;
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Oldest note is compared against each record as it is taken
   always @(posedge clk_in)
   begin
      if (skip_e > 0)
         skip_e--;
      else if (rec_valid === 1'b1 && rec_ready_in)
      begin
         if (exp_q.size() == 0)
            chk("extra", 32'h0000_0000, 32'(rec.cmd) + 1);
         else
            chk_rec(exp_q.pop_front(), el_q.pop_front());
      end
   end

   // Hang guard, several times the length of the whole run
   always @(posedge clk_in)
   begin
      cyc_n++;
      if (cyc_n == 5000)
      begin
         fail_count++;
         wrap_up();
      end
   end

   initial
   begin
      ddrdec_cfg_t c;
      @(negedge clk_in);
      start(3, CFG_RESET);
      // Every rank, opcode and variant back to back, plus one bad select
      for (int r = 0; r < 4; r++)
         for (int op = 0; op < 8; op++)
            for (int ap = 0; ap < 2; ap++)
               step(~(4'h1 << r), 3'(op), {lf[15:11], ap[0], lf[9:0]},
                  lf[18:16]);
      step(4'hC, 3'h5, 16'h0000, 3'h1);
      idle(30);
      // Random traffic under six setting combinations
      for (int k = 0; k < 6; k++)
      begin
         c = CFG_RESET;
         c.burst = ddrdec_bl_t'(k % 3);
         c.read_lat = 4'(rl[k]);
         c.add_lat = ddrdec_al_t'((k / 2) % 3);
         c.write_lat = 4'(5 + k % 4);
         c.registered = k[0];
         c.dm_strobe = k[1];
         c.view = ddrdec_view_t'(k % 4);
         start(1, c);
         repeat (60)
            step((lf[2] && lf[3]) ? ~(4'h1 << lf[1:0]) : 4'hF, lf[6:4],
               lf[31:16], lf[9:7]);
         idle(30);
      end
      // Stalled receiver: two beats kept, the rest refused
      c = CFG_RESET;
      c.view = VIEW_DATA;
      start(1, c);
      rec_ready_in = 1'b0;
      step(CS_RANK0, 3'h4, 16'h0000, 3'h2);
      idle(10);
      chk("overrun", 32'h0000_0001, 32'(overrun));
      rec_ready_in = 1'b1;
      overrun_clr_in = 1'b1;
      idle(1);
      overrun_clr_in = 1'b0;
      idle(3);
      chk("overrun", 32'h0000_0000, 32'(overrun));
      // Reset inside a pending read window leaves no tagged beats
      step(CS_RANK1, 3'h5, 16'h0000, 3'h3);
      idle(1);
      start(1, c);
      idle(15);
      chk("left", 32'h0000_0000, 32'(exp_q.size()));
      wrap_up();
   end
endmodule

`default_nettype wire
